// ==== shared/sfpfc_pkg.sv ====
// Shared types, constants and lane helpers for the serial flash pin front end
package sfpfc_pkg;
    // Lane width of the current instruction phase
    typedef enum logic [1:0] {
        LM_SINGLE = 2'b00,
        LM_DUAL = 2'b01,
        LM_QUAD = 2'b10
    } sfpfc_lane_t;

    // Host link sequencer states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_OPEN = 3'b001,
        HS_READY = 3'b010,
        HS_LOW = 3'b011,
        HS_HIGH = 3'b100,
        HS_CLOSE = 3'b101
    } sfpfc_hst_t;

    // Status register: write disable, quad enable, four block protect bits
    localparam int STS_SWD = 7;
    localparam int STS_QE = 6;
    localparam logic [7:0] STS_PROT_MASK = 8'hFC;
    localparam logic [7:0] STS_RESET = 8'h00;
    // Read register: shared lane-3 pin role
    localparam int RDR_ROLE = 7;
    localparam logic [7:0] RDR_RESET = 8'h00;
    // Function register: separate reset pin disable
    localparam int FNR_RSTDIS = 0;
    localparam logic [7:0] FNR_RESET = 8'h00;

    // Host serial clock half period, least time rounded up
    localparam int MCLK_PERIOD_NS = 40;
    localparam int SCK_HALF_NS = 320;
    localparam int SCK_HALF_CYC_DEF = (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    localparam logic [3:0] MASK_LANE0 = 4'h1;
    localparam logic [3:0] MASK_LANE1 = 4'h2;
    localparam logic [3:0] MASK_DUAL = 4'h3;
    localparam logic [3:0] MASK_QUAD = 4'hF;
    localparam logic [3:0] MASK_CTRL = 4'hC;

    // Lanes in use; single mode uses the lane given by the caller
    function automatic logic [3:0] laneMask(sfpfc_lane_t m, logic [3:0] single);
        case (m)
            LM_DUAL: laneMask = MASK_DUAL;
            LM_QUAD: laneMask = MASK_QUAD;
            default: laneMask = single;
        endcase
    endfunction

    // Collect inbound lanes into the low bits
    function automatic logic [3:0] gatherIn(sfpfc_lane_t m, logic [3:0] lanes, logic [3:0] single);
        if (m == LM_SINGLE) begin
            gatherIn = {3'h0, |(lanes & single)};
        end else begin
            gatherIn = lanes & laneMask(m, single);
        end
    endfunction

    // Place outbound bits onto their lanes
    function automatic logic [3:0] spreadOut(sfpfc_lane_t m, logic [3:0] bits, logic [3:0] single);
        if (m == LM_SINGLE) begin
            spreadOut = bits[0] ? single : 4'h0;
        end else begin
            spreadOut = bits & laneMask(m, single);
        end
    endfunction
endpackage

// ==== shared/sfpfc_if.sv ====
// Pin-level link between the flash device end and the host controller end
`timescale 1ns/1ps
`default_nettype none
interface sfpfc_if;
    logic sck;
    logic selN;
    logic rstPinN;
    logic [3:0] hostOut;
    logic [3:0] hostOe;
    logic [3:0] devOut;
    logic [3:0] devOe;
    logic [3:0] laneLevel;

    // Wired lane level; undriven lanes read high as through a pull-up
    assign laneLevel = (devOe & devOut) | (hostOe & hostOut) | ~(devOe | hostOe);

    modport dev (input sck, input selN, input rstPinN, input laneLevel, output devOut, output devOe);
    modport host (output sck, output selN, output rstPinN, output hostOut, output hostOe, input laneLevel);
endinterface
`default_nettype wire

// ==== rtl/sfpfc_device.sv ====
// Device end of the serial flash pin front end: lane capture, lane drive, pin roles
`timescale 1ns/1ps
`default_nettype none
module sfpfc_device
    import sfpfc_pkg::*;
#(
    parameter bit SEP_RESET = 1'b0 // Variant with a separate reset pin
) (
    input wire logic mclk, // Block clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    sfpfc_if.dev link, // Flash pins
    input wire sfpfc_lane_t laneMode, // Lane width of the current phase
    input wire logic txDrive, // Drive txBits at the next clock fall
    input wire logic [3:0] txBits, // Outbound bits, low bits first used
    output logic [3:0] rxBits, // Bits captured at the last clock rise
    output logic rxStrobe, // One-cycle pulse per captured beat
    output logic txStrobe, // One-cycle pulse per driven beat
    output logic [7:0] beatCount, // Beats captured in this selection
    output logic selActive, // Selected, armed and not paused or reset
    output logic standby, // Deselected, low-power state
    output logic paused, // Pause in force
    output logic inReset, // Hardware reset in force
    output logic wpLow, // Write protect pin asserted
    input wire logic statusWe, // Status register write strobe
    input wire logic [7:0] statusWd, // Status write data
    output logic [7:0] statusQ, // Status register
    output logic statusRefused, // Pulse: protected bits were kept
    input wire logic readRegWe, // Read register write strobe
    input wire logic [7:0] readRegWd, // Read register write data
    output logic [7:0] readRegQ, // Read register
    input wire logic funcWe, // Function register write strobe
    input wire logic [7:0] funcWd, // Function register write data
    output logic [7:0] funcQ // Function register
);
    logic [6:0] pinS1_r;
    logic [6:0] pinS2_r;
    logic sckPrev_r;
    logic selPrev_r;
    logic txnOk_r;
    logic [3:0] rxBits_r;
    logic rxStrobe_r;
    logic txStrobe_r;
    logic [7:0] beatCount_r;
    logic [3:0] oeWant_r;
    logic [3:0] devOe_r;
    logic [3:0] devOut_r;
    logic [7:0] statusQ_r;
    logic statusRefused_r;
    logic [7:0] readReg_r;
    logic [7:0] funcReg_r;
    logic selActive_r;
    logic standby_r;
    logic paused_r;
    logic inReset_r;
    logic wpLow_r;

    // Two-stage synchronisers for every pin; stage one feeds stage two only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Lanes and reset pin start at their pulled-up idle, so no false pause or reset;
            // select starts low so a select already low at release is never armed
            pinS1_r <= 7'h4F;
            pinS2_r <= 7'h4F;
            sckPrev_r <= 1'b0;
            selPrev_r <= 1'b0;
        end else if (ce) begin
            pinS1_r <= {link.rstPinN, link.selN, link.sck, link.laneLevel};
            pinS2_r <= pinS1_r;
            sckPrev_r <= pinS2_r[4];
            selPrev_r <= pinS2_r[5];
        end
    end

    // Synchronised pin levels and configuration bits
    wire [3:0] lanesS = pinS2_r[3:0];
    wire sckS = pinS2_r[4];
    wire selNS = pinS2_r[5];
    wire rstPinS = pinS2_r[6];
    wire quadOn = statusQ_r[STS_QE];
    wire pinRole = readReg_r[RDR_ROLE];

    // Lane3 pin role and the separate reset pin
    wire sepReset = !rstPinS && !funcReg_r[FNR_RSTDIS];
    wire sharedReset = !quadOn && pinRole && !lanesS[3];
    wire hwReset = SEP_RESET ? sepReset : sharedReset;
    wire pauseRole = !quadOn && (SEP_RESET || !pinRole);
    wire pauseAct = pauseRole && !lanesS[3] && !selNS;

    // Write protect pin only counts while lane2 is not data
    wire wpAsserted = !quadOn && !lanesS[2];
    wire protect = statusQ_r[STS_SWD] && wpAsserted;

    // Edges of the sampled clock; polarity at idle does not matter
    wire sckRise = sckS && !sckPrev_r;
    wire sckFall = !sckS && sckPrev_r;
    wire selFall = selPrev_r && !selNS;

    // Transfer may proceed only when armed, selected, not paused or reset
    wire live = txnOk_r && !selNS && !hwReset && !pauseAct;
    wire [3:0] driveMask = laneMask(laneMode, MASK_LANE1);
    wire [3:0] fallOe = txDrive ? driveMask : 4'h0;
    wire [3:0] oeNext = sckFall ? fallOe : oeWant_r;
    wire [3:0] inBits = gatherIn(laneMode, lanesS, MASK_LANE0);
    wire [3:0] outBits = spreadOut(laneMode, txBits, MASK_LANE1);
    wire [7:0] statusKeep = statusQ_r & STS_PROT_MASK;
    wire [7:0] statusFree = statusWd & ~STS_PROT_MASK;
    wire [7:0] statusNext = protect ? (statusFree | statusKeep) : statusWd;

    // A selection only counts if its falling edge was seen since reset;
    // the synchroniser resets low so a select already low is never armed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txnOk_r <= 1'b0;
        end else if (ce) begin
            if (selNS || hwReset) begin
                txnOk_r <= 1'b0;
            end else if (selFall) begin
                txnOk_r <= 1'b1;
            end
        end
    end

    // Inbound capture on the clock rise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxBits_r <= 4'h0;
            rxStrobe_r <= 1'b0;
        end else if (ce) begin
            rxStrobe_r <= sckRise && live;
            if (sckRise && live) begin
                rxBits_r <= inBits;
            end
        end
    end

    // Beat count restarts with every selection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            beatCount_r <= 8'h00;
        end else if (ce) begin
            if (selFall) begin
                beatCount_r <= 8'h00;
            end else if (sckRise && live) begin
                beatCount_r <= beatCount_r + 8'h01;
            end
        end
    end

    // Lane enables wanted by the sequence; pause keeps them for resume
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oeWant_r <= 4'h0;
        end else if (ce) begin
            if (selNS || hwReset || !txnOk_r) begin
                oeWant_r <= 4'h0;
            end else if (sckFall && live) begin
                oeWant_r <= fallOe;
            end
        end
    end

    // Outbound data changes only on a clock fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            devOut_r <= 4'h0;
            txStrobe_r <= 1'b0;
        end else if (ce) begin
            txStrobe_r <= sckFall && live && txDrive;
            if (sckFall && live && txDrive) begin
                devOut_r <= outBits;
            end
        end
    end

    // Pins float while deselected, paused or in reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            devOe_r <= 4'h0;
        end else if (ce) begin
            devOe_r <= live ? oeNext : 4'h0;
        end
    end

    // Configuration registers survive hardware reset, like nonvolatile bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            statusQ_r <= STS_RESET;
            statusRefused_r <= 1'b0;
            readReg_r <= RDR_RESET;
            funcReg_r <= FNR_RESET;
        end else if (ce) begin
            statusRefused_r <= statusWe && protect;
            if (statusWe) begin
                statusQ_r <= statusNext;
            end
            if (readRegWe) begin
                readReg_r <= readRegWd;
            end
            if (funcWe) begin
                funcReg_r <= funcWd;
            end
        end
    end

    // State flags for the core; standby gates its non-essential logic
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selActive_r <= 1'b0;
            standby_r <= 1'b1;
            paused_r <= 1'b0;
            inReset_r <= 1'b0;
            wpLow_r <= 1'b0;
        end else if (ce) begin
            selActive_r <= live;
            standby_r <= selNS;
            paused_r <= pauseAct;
            inReset_r <= hwReset;
            wpLow_r <= wpAsserted;
        end
    end

    // Outputs straight from flip-flops
    assign link.devOut = devOut_r;
    assign link.devOe = devOe_r;
    assign rxBits = rxBits_r;
    assign rxStrobe = rxStrobe_r;
    assign txStrobe = txStrobe_r;
    assign beatCount = beatCount_r;
    assign selActive = selActive_r;
    assign standby = standby_r;
    assign paused = paused_r;
    assign inReset = inReset_r;
    assign wpLow = wpLow_r;
    assign statusQ = statusQ_r;
    assign statusRefused = statusRefused_r;
    assign readRegQ = readReg_r;
    assign funcQ = funcReg_r;
endmodule
`default_nettype wire

// ==== rtl/sfpfc_host.sv ====
// Host end of the serial flash link: clock divider, select, lane drive and sampling
`timescale 1ns/1ps
`default_nettype none
module sfpfc_host
    import sfpfc_pkg::*;
#(
    parameter int SCK_HALF_CYC = SCK_HALF_CYC_DEF, // Serial clock half period in mclk cycles
    parameter bit IDLE_HIGH = 1'b0 // Clock idles high when set
) (
    input wire logic mclk, // Block clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    sfpfc_if.host link, // Flash pins
    input wire logic openReq, // Level: begin a selection
    input wire logic closeReq, // Level: end the selection
    input wire logic beatReq, // Level: run one clock beat
    input wire logic beatDrive, // Beat drives beatBits, else releases
    input wire logic [3:0] beatBits, // Outbound bits of the beat
    input wire sfpfc_lane_t laneMode, // Lane width of the beat
    input wire logic wpLevel, // Write protect level when lane2 is control
    input wire logic holdLevel, // Pause or reset level when lane3 is control
    input wire logic resetReq, // Request on the separate reset pin
    input wire logic deviceBusy, // Internal write in progress
    output logic linkOpen, // Select is low
    output logic beatDone, // One-cycle pulse at the end of a beat
    output logic [3:0] beatRx // Bits sampled at the beat clock rise
);
    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);

    if (SCK_HALF_CYC < 2 || SCK_HALF_CYC > 255) begin : gBadHalf
        $error("SCK_HALF_CYC must lie in 2..255");
    end

    sfpfc_hst_t st_r;
    logic [7:0] cnt_r;
    logic sck_r;
    logic selN_r;
    logic rstPinN_r;
    logic linkOpen_r;
    logic beatDone_r;
    logic [3:0] beatRx_r;
    sfpfc_lane_t mode_r;
    logic [3:0] dataOut_r;
    logic [3:0] dataOe_r;
    logic [3:0] pinOut_r;
    logic [3:0] pinOe_r;
    logic [3:0] laneS1_r;
    logic [3:0] laneS2_r;

    // Phase timing and lane selection
    wire halfDone = cnt_r == HALF_LAST;
    wire timed = (st_r == HS_OPEN) || (st_r == HS_LOW) || (st_r == HS_HIGH) || (st_r == HS_CLOSE);
    wire takeBeat = (st_r == HS_READY) && beatReq && !beatDone_r;
    wire takeClose = (st_r == HS_READY) && !beatReq && closeReq && !beatDone_r;
    wire [3:0] ctrlMask = (mode_r == LM_QUAD) ? 4'h0 : MASK_CTRL;
    wire [3:0] ctrlBits = {holdLevel, wpLevel, 2'b00};
    wire [3:0] beatMask = laneMask(laneMode, MASK_LANE0);
    wire [3:0] beatOut = spreadOut(laneMode, beatBits, MASK_LANE0);
    wire [3:0] rxNext = gatherIn(mode_r, laneS2_r, MASK_LANE1);

    // Lane inputs pass two flip-flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            laneS1_r <= 4'hF;
            laneS2_r <= 4'hF;
        end else if (ce) begin
            laneS1_r <= link.laneLevel;
            laneS2_r <= laneS1_r;
        end
    end

    // Phase counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (ce) begin
            cnt_r <= (timed && !halfDone) ? cnt_r + 8'h01 : 8'h00;
        end
    end

    // Link sequencer: select, half-period low with data, rise, half-period high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= HS_IDLE;
            sck_r <= IDLE_HIGH;
            selN_r <= 1'b1;
            mode_r <= LM_SINGLE;
            dataOut_r <= 4'h0;
            dataOe_r <= 4'h0;
            beatRx_r <= 4'h0;
        end else if (ce) begin
            case (st_r)
                HS_IDLE: begin
                    if (openReq) begin
                        selN_r <= 1'b0;
                        st_r <= HS_OPEN;
                    end
                end
                HS_OPEN: begin
                    if (halfDone) begin
                        st_r <= HS_READY;
                    end
                end
                HS_READY: begin
                    if (takeBeat) begin
                        sck_r <= 1'b0;
                        mode_r <= laneMode;
                        dataOut_r <= beatOut;
                        dataOe_r <= beatDrive ? beatMask : 4'h0;
                        st_r <= HS_LOW;
                    end else if (takeClose) begin
                        sck_r <= IDLE_HIGH;
                        st_r <= HS_CLOSE;
                    end
                end
                HS_LOW: begin
                    if (halfDone) begin
                        sck_r <= 1'b1;
                        beatRx_r <= rxNext;
                        st_r <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (halfDone) begin
                        st_r <= HS_READY;
                    end
                end
                HS_CLOSE: begin
                    if (halfDone) begin
                        selN_r <= 1'b1;
                        dataOe_r <= 4'h0;
                        st_r <= HS_IDLE;
                    end
                end
                default: begin
                    st_r <= HS_IDLE;
                end
            endcase
        end
    end

    // Pins are registered; reset is held off while the device is busy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut_r <= 4'h0;
            pinOe_r <= 4'h0;
            rstPinN_r <= 1'b1;
            linkOpen_r <= 1'b0;
            beatDone_r <= 1'b0;
        end else if (ce) begin
            pinOut_r <= (dataOut_r & ~ctrlMask) | (ctrlBits & ctrlMask);
            pinOe_r <= dataOe_r | ctrlMask;
            rstPinN_r <= !(resetReq && !deviceBusy);
            linkOpen_r <= !selN_r;
            beatDone_r <= (st_r == HS_HIGH) && halfDone;
        end
    end

    assign link.sck = sck_r;
    assign link.selN = selN_r;
    assign link.rstPinN = rstPinN_r;
    assign link.hostOut = pinOut_r;
    assign link.hostOe = pinOe_r;
    assign linkOpen = linkOpen_r;
    assign beatDone = beatDone_r;
    assign beatRx = beatRx_r;
endmodule
`default_nettype wire

// ==== dv/sfpfc_asserts.sv ====
// Concurrent checks on the pins between the device end and the host end
`timescale 1ns/1ps
`default_nettype none
module sfpfc_asserts (
    input wire logic mclk, // Block clock
    input wire logic rst_n, // Reset, active low
    input wire logic sck, // Serial clock
    input wire logic selN, // Select, active low
    input wire logic [3:0] hostOut, // Host lane data
    input wire logic [3:0] hostOe, // Host lane enables
    input wire logic [3:0] devOut, // Device lane data
    input wire logic [3:0] devOe // Device lane enables
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Long enough for the pin synchroniser to have seen the level
    sequence deselHeld;
        selN [*6];
    endsequence
    sequence pauseHeld;
        (hostOe[3] && !hostOut[3]) [*6];
    endsequence

    // Deselect and pause float every lane
    desel_float_a: assert property (deselHeld |-> devOe == 4'h0)
        else $error("lane driven while deselected");
    lanes_released_a: assert property ($rose(selN) |-> ##[1:6] devOe == 4'h0)
        else $error("lanes still driven after deselect");
    pause_float_a: assert property (pauseHeld |-> devOe == 4'h0)
        else $error("lane driven while paused or in reset");
    // Device output only moves in the low phase that follows a clock fall
    fall_drive_a: assert property ($changed(devOut) |-> !sck && !$past(sck, 2) && $past(sck, 6))
        else $error("device data changed away from a clock fall");
    oe_rise_a: assert property ($rose(|devOe) |-> !sck && !selN)
        else $error("device enable rose outside a selected low phase");
    lane_set_a: assert property (devOe == 4'h0 || devOe == 4'h2 || devOe == 4'h3 || devOe == 4'hF)
        else $error("device drives an illegal lane set");
    no_clash_a: assert property ((devOe & hostOe) == 4'h0)
        else $error("both ends drive one lane");
    // Mode 0 host: clock stands low between frames
    sck_idle_a: assert property (selN && $past(selN) |-> !sck)
        else $error("serial clock not idle while deselected");
endmodule
`default_nettype wire

// ==== dv/sfpfc_bench.sv ====
// Testbench joining the device end and the host end across the pin interface
`timescale 1ns/1ps
`default_nettype none
module sfpfc_bench;
    import sfpfc_pkg::*;
    localparam logic [7:0] HOST_BYTE = 8'hA5;
    localparam logic [7:0] DEV_BYTE = 8'h3C;
    logic mclk, rst_n, ce, openReq, closeReq, beatReq, beatDrive, txDrive, rqRst, busy;
    logic wpLevel, holdLevel, statusWe, readRegWe, funcWe, paused, inReset, selActive, linkOpen, beatDone, refused;
    logic [3:0] beatBits, txBits, rxBits, beatRx;
    logic [7:0] wd, statusQ, beatCount;
    sfpfc_lane_t mode, lm;
    int n_errors, checks, cyc;
    sfpfc_if link ();

    sfpfc_device sfpfc_device_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .link(link.dev), .laneMode(mode),
        .txDrive(txDrive), .txBits(txBits), .rxBits(rxBits), .rxStrobe(), .txStrobe(), .beatCount(beatCount),
        .selActive(selActive), .standby(), .paused(paused), .inReset(inReset), .wpLow(), .statusWe(statusWe),
        .statusWd(wd), .statusQ(statusQ), .statusRefused(refused), .readRegWe(readRegWe), .readRegWd(wd),
        .readRegQ(), .funcWe(funcWe), .funcWd(wd), .funcQ());
    sfpfc_host sfpfc_host_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .link(link.host), .openReq(openReq),
        .closeReq(closeReq), .beatReq(beatReq), .beatDrive(beatDrive), .beatBits(beatBits), .laneMode(mode),
        .wpLevel(wpLevel), .holdLevel(holdLevel), .resetReq(rqRst), .deviceBusy(busy), .linkOpen(linkOpen),
        .beatDone(beatDone), .beatRx(beatRx));
    sfpfc_asserts sfpfc_asserts_inst (.mclk(mclk), .rst_n(rst_n), .sck(link.sck), .selN(link.selN),
        .hostOut(link.hostOut), .hostOe(link.hostOe), .devOut(link.devOut), .devOe(link.devOe));

    // Lanes that carry bits in each width
    function automatic logic [3:0] keep(sfpfc_lane_t m, logic [3:0] b);
        keep = (m == LM_QUAD) ? b : ((m == LM_DUAL) ? (b & 4'h3) : (b & 4'h1));
    endfunction

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hangs are caught by the cycle ceiling, not here
    task automatic waitHi(ref logic sig);
        do @(negedge mclk); while (sig !== 1'b1);
    endtask

    task automatic openLink();
        @(posedge mclk) openReq <= 1'b1;
        waitHi(linkOpen);
        @(posedge mclk) openReq <= 1'b0;
    endtask

    // Settle time lets the device see the deselect before the next select
    task automatic closeLink();
        @(posedge mclk) closeReq <= 1'b1;
        do @(negedge mclk); while (linkOpen !== 1'b0);
        @(posedge mclk) closeReq <= 1'b0;
        repeat (8) @(negedge mclk);
    endtask

    // Gap before each beat keeps txDrive stable across the previous clock fall
    task automatic beat(sfpfc_lane_t m, logic hd, logic [3:0] hb, logic dd, logic [3:0] db);
        repeat (6) @(posedge mclk);
        mode <= m;
        beatDrive <= hd;
        beatBits <= hb;
        txDrive <= dd;
        txBits <= db;
        beatReq <= 1'b1;
        waitHi(beatDone);
        @(posedge mclk) beatReq <= 1'b0;
    endtask

    task automatic stsWrite(logic [7:0] d, logic [7:0] exp);
        repeat (6) @(posedge mclk);
        wd <= d;
        statusWe <= 1'b1;
        @(posedge mclk) statusWe <= 1'b0;
        // Only a refused write leaves a result that differs from the data written
        @(negedge mclk) check("refused", {7'h0, refused}, {7'h0, exp != d});
        @(negedge mclk) check("status", statusQ, exp);
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Ceiling well above the several hundred cycles the sequence needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_n, openReq, closeReq, beatReq, beatDrive, txDrive, rqRst, busy} = '0;
        {statusWe, readRegWe, funcWe, beatBits, txBits, wd} = '0;
        {ce, wpLevel, holdLevel} = 3'h7;
        mode = LM_SINGLE;
        lm = LM_SINGLE;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        // One byte to the device and its last seven bits back, on single lanes
        openLink();
        for (int i = 7; i >= 0; i--) begin
            beat(LM_SINGLE, 1'b1, {3'h0, HOST_BYTE[i]}, 1'b1, {3'h0, DEV_BYTE[i]});
            check("rx single", 8'(rxBits), {7'h0, HOST_BYTE[i]});
            // Clock idles low, so the first beat has no fall to drive from
            if (i < 7) check("read single", 8'(beatRx), {7'h0, DEV_BYTE[i]});
        end
        check("count", beatCount, 8'h08);
        closeLink();
        check("lanes idle", 8'(link.devOe), 8'h00);
        // Status protection against the write-protect pin
        @(posedge mclk) wpLevel <= 1'b0;
        stsWrite(8'hBC, 8'hBC);
        stsWrite(8'h03, 8'hBF);
        @(posedge mclk) wpLevel <= 1'b1;
        stsWrite(8'h03, 8'h03);
        stsWrite(8'hC0, 8'hC0);
        @(posedge mclk) wpLevel <= 1'b0;
        stsWrite(8'h40, 8'h40);
        // Dual then quad: write, turnaround, read
        openLink();
        for (int k = 0; k < 2; k++) begin
            lm = k ? LM_QUAD : LM_DUAL;
            beat(lm, 1'b1, 4'h2, 1'b0, 4'h0);
            check("rx lanes", 8'(rxBits), 8'(keep(lm, 4'h2)));
            beat(lm, 1'b0, 4'h0, 1'b1, 4'hD);
            check("read lanes", 8'(beatRx), 8'(keep(lm, 4'hD)));
            // Idle beat hands the lanes back before the next write
            beat(lm, 1'b0, 4'h0, 1'b0, 4'h0);
        end
        closeLink();
        stsWrite(8'h00, 8'h00);
        @(posedge mclk) wpLevel <= 1'b1;
        // Pause freezes the sequence and resumes it
        openLink();
        beat(LM_SINGLE, 1'b1, 4'h1, 1'b0, 4'h0);
        @(posedge mclk) holdLevel <= 1'b0;
        repeat (6) @(negedge mclk);
        check("paused", {7'h0, paused}, 8'h01);
        beat(LM_SINGLE, 1'b1, 4'h0, 1'b0, 4'h0);
        check("frozen", 8'(rxBits), 8'h01);
        check("count", beatCount, 8'h01);
        @(posedge mclk) holdLevel <= 1'b1;
        beat(LM_SINGLE, 1'b1, 4'h0, 1'b0, 4'h0);
        check("resumed", 8'(rxBits), 8'h00);
        check("count", beatCount, 8'h02);
        // Shared pin as hardware reset, then a fresh select is needed
        @(posedge mclk);
        wd <= 8'h80;
        readRegWe <= 1'b1;
        @(posedge mclk) readRegWe <= 1'b0;
        @(posedge mclk) holdLevel <= 1'b0;
        repeat (6) @(negedge mclk);
        check("reset role", {6'h0, inReset, paused}, 8'h02);
        @(posedge mclk) holdLevel <= 1'b1;
        repeat (6) @(negedge mclk);
        check("not rearmed", {7'h0, selActive}, 8'h00);
        closeLink();
        // Reset request waits while the device is busy storing data
        @(posedge mclk) {rqRst, busy} <= 2'h3;
        repeat (3) @(negedge mclk);
        check("reset held off", {7'h0, link.rstPinN}, 8'h01);
        @(posedge mclk) busy <= 1'b0;
        repeat (3) @(negedge mclk);
        check("reset pin", {7'h0, link.rstPinN}, 8'h00);
        @(posedge mclk) rqRst <= 1'b0;
        repeat (3) @(negedge mclk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
